// ### rtl/oas_defines.svh
// Purpose: addresses, field positions, reset values and timings of the acquisition sequencer
// Assumes: byte-wide registers on the device register port
// Notes: led and conversion times are in microseconds, clock figures in nanoseconds; cycle counts are derived from the clock period
`ifndef OAS_DEFINES_SVH
`define OAS_DEFINES_SVH
// register addresses
`define OAS_A_MODE 8'h09
`define OAS_A_ACQ 8'h0A
`define OAS_A_AMP0 8'h0C
`define OAS_A_AMP1 8'h0D
`define OAS_A_AMP2 8'h0E
`define OAS_A_AMP3 8'h0F
`define OAS_A_SLOT_LO 8'h11
`define OAS_A_SLOT_HI 8'h12
`define OAS_A_TWHOLE 8'h1F
`define OAS_A_TEMP_FRAC 8'h20
`define OAS_A_TTRIG 8'h21
`define OAS_RST_BYTE 8'h00
// field positions
`define OAS_SHDN_BIT 7
`define OAS_MODE_MSB 2
`define OAS_RGE_MSB 6
`define OAS_RGE_LSB 5
`define OAS_SR_MSB 4
`define OAS_SR_LSB 2
`define OAS_PW_MSB 1
`define OAS_SLOT_A_MSB 2
`define OAS_SLOT_B_MSB 5
`define OAS_SLOT_B_LSB 3
`define OAS_TRIG_BIT 0
`define OAS_TEMP_FRAC_MSB 3
// clock and time base
`define OAS_CLK_NS 100
`define OAS_US_NS 1000
`define OAS_US_CYC (`OAS_US_NS / `OAS_CLK_NS)
`define OAS_US_PER_S 1000000
`define OAS_TEMP_CONV_US 100
// led pulse widths and rising-edge spacing, microseconds
`define OAS_PW0_US 11'd69
`define OAS_PW1_US 11'd118
`define OAS_PW2_US 11'd215
`define OAS_PW3_US 11'd411
`define OAS_SPC0_US 11'd427
`define OAS_SPC1_US 11'd525
`define OAS_SPC2_US 11'd720
`define OAS_SPC3_US 11'd1107
// sample rates, samples per second
`define OAS_SR0 50
`define OAS_SR1 100
`define OAS_SR2 200
`define OAS_SR3 400
`define OAS_SR4 800
`define OAS_SR5 1000
`define OAS_SR6 1600
`define OAS_SR7 3200
// highest rate code allowed for each pulse width code
`define OAS_SR_MAX_PW0 3'h7
`define OAS_SR_MAX_PW1 3'h6
`define OAS_SR_MAX_PW2 3'h5
`define OAS_SR_MAX_PW3 3'h4
// converter full scale (nA) and resolution (bits)
`define OAS_FS0_NA 15'h0800
`define OAS_FS1_NA 15'h1000
`define OAS_FS2_NA 15'h2000
`define OAS_FS3_NA 15'h4000
`define OAS_RES0 5'h0F
`define OAS_RES1 5'h10
`define OAS_RES2 5'h11
`define OAS_RES3 5'h12
`define OAS_ADC_W 18
`endif

// ### rtl/oas_pkg.sv
// Purpose: types shared by the acquisition sequencer
// Assumes: nothing beyond the defines header
// Notes: holds enumerations only
`default_nettype none
package oas_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SCAN = 3'h1,
      ST_PULSE = 3'h2,
      ST_EMIT = 3'h3,
      ST_SPACE = 3'h4
   } oas_state_t;
   // operating mode codes
   typedef enum logic [2:0] {
      MODE_HEART = 3'h2,
      MODE_DUAL = 3'h3,
      MODE_SLOT = 3'h7
   } oas_mode_t;
   // slot source codes
   typedef enum logic [2:0] {
      SRC_OFF = 3'h0,
      SRC_RED = 3'h1,
      SRC_IR = 3'h2,
      SRC_GREEN = 3'h3,
      SRC_DARK = 3'h4
   } oas_src_t;
endpackage
`default_nettype wire

// ### rtl/oas_sequencer.sv
// Purpose: optical acquisition sequencer: settings, led slots, sample bytes, die temperature
// Assumes: register port and converter inputs synchronous to clock
// Notes: sample bytes leave through a two-entry skid buffer with valid/ready
`timescale 1ns/1ps
`default_nettype none
`include "oas_defines.svh"

module oas_sequencer #(
   parameter int unsigned US_CYC = `OAS_US_CYC,
   parameter int unsigned TEMP_CONV_US = `OAS_TEMP_CONV_US
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // converter and temperature sensor
   input wire logic [`OAS_ADC_W-1:0] adc_result,
   input wire logic [7:0] temp_sensor_whole,
   input wire logic [3:0] temp_sensor_frac,
   output logic adc_integrate,
   output logic [14:0] adc_full_scale_na,
   output logic [4:0] adc_resolution_bits,
   output logic temp_conv_active,
   // led drive
   output logic [3:0] led_enable,
   output logic [7:0] red_drive_level,
   output logic [7:0] infrared_drive_level,
   output logic [7:0] green_a_drive_level,
   output logic [7:0] green_b_drive_level,
   // sample byte stream
   output logic [7:0] fifo_byte,
   output logic fifo_valid,
   input wire logic fifo_ready
);

   function automatic logic [10:0] pw_us(input logic [1:0] pw);
      case (pw)
         2'h0: pw_us = `OAS_PW0_US;
         2'h1: pw_us = `OAS_PW1_US;
         2'h2: pw_us = `OAS_PW2_US;
         default: pw_us = `OAS_PW3_US;
      endcase
   endfunction

   function automatic logic [10:0] spc_us(input logic [1:0] pw);
      case (pw)
         2'h0: spc_us = `OAS_SPC0_US;
         2'h1: spc_us = `OAS_SPC1_US;
         2'h2: spc_us = `OAS_SPC2_US;
         default: spc_us = `OAS_SPC3_US;
      endcase
   endfunction

   function automatic logic [14:0] period_us(input logic [2:0] sr);
      case (sr)
         3'h0: period_us = 15'(`OAS_US_PER_S / `OAS_SR0);
         3'h1: period_us = 15'(`OAS_US_PER_S / `OAS_SR1);
         3'h2: period_us = 15'(`OAS_US_PER_S / `OAS_SR2);
         3'h3: period_us = 15'(`OAS_US_PER_S / `OAS_SR3);
         3'h4: period_us = 15'(`OAS_US_PER_S / `OAS_SR4);
         3'h5: period_us = 15'(`OAS_US_PER_S / `OAS_SR5);
         3'h6: period_us = 15'(`OAS_US_PER_S / `OAS_SR6);
         default: period_us = 15'(`OAS_US_PER_S / `OAS_SR7);
      endcase
   endfunction

   function automatic logic [2:0] sr_max(input logic [1:0] pw);
      case (pw)
         2'h0: sr_max = `OAS_SR_MAX_PW0;
         2'h1: sr_max = `OAS_SR_MAX_PW1;
         2'h2: sr_max = `OAS_SR_MAX_PW2;
         default: sr_max = `OAS_SR_MAX_PW3;
      endcase
   endfunction

   // source code of channel k under the current mode
   function automatic logic [2:0] chan_src(input logic [2:0] mode, input logic [1:0] k,
                                           input logic [7:0] lo, input logic [7:0] hi);
      case (mode)
         oas_pkg::MODE_HEART: chan_src = (k == 2'h0) ? oas_pkg::SRC_RED : oas_pkg::SRC_OFF;
         oas_pkg::MODE_DUAL: chan_src = (k == 2'h0) ? oas_pkg::SRC_RED :
                                        (k == 2'h1) ? oas_pkg::SRC_IR : oas_pkg::SRC_OFF;
         oas_pkg::MODE_SLOT: case (k)
            2'h0: chan_src = lo[`OAS_SLOT_A_MSB:0];
            2'h1: chan_src = lo[`OAS_SLOT_B_MSB:`OAS_SLOT_B_LSB];
            2'h2: chan_src = hi[`OAS_SLOT_A_MSB:0];
            default: chan_src = hi[`OAS_SLOT_B_MSB:`OAS_SLOT_B_LSB];
         endcase
         default: chan_src = oas_pkg::SRC_OFF;
      endcase
   endfunction

   // registers
   logic [7:0] mode_reg;
   logic [7:0] acq_reg;
   logic [7:0] amp_reg [4];
   logic [7:0] slot_lo_reg;
   logic [7:0] slot_hi_reg;
   logic [7:0] twhole_reg;
   logic [3:0] temp_frac_reg;
   logic trig_reg;
   logic [15:0] temp_us_reg;
   logic [7:0] pre_reg;
   logic [14:0] sample_us_reg;
   logic pend_reg;
   oas_pkg::oas_state_t st_reg, st_next;
   logic [2:0] k_reg, k_next;
   logic [2:0] src_reg, src_next;
   logic [10:0] chan_us_reg, chan_us_next;
   logic [1:0] byte_reg, byte_next;
   logic [`OAS_ADC_W-1:0] samp_reg, samp_next;
   logic [7:0] skid_reg;
   logic skid_v_reg;

   // register port decode
   wire wr_mode = reg_wr && (reg_addr == `OAS_A_MODE);
   wire wr_acq = reg_wr && (reg_addr == `OAS_A_ACQ);
   wire wr_lo = reg_wr && (reg_addr == `OAS_A_SLOT_LO);
   wire wr_hi = reg_wr && (reg_addr == `OAS_A_SLOT_HI);
   wire wr_tw = reg_wr && (reg_addr == `OAS_A_TWHOLE);
   wire wr_tf = reg_wr && (reg_addr == `OAS_A_TEMP_FRAC);
   wire wr_trig = reg_wr && (reg_addr == `OAS_A_TTRIG);
   wire amp_hit = reg_wr && (reg_addr[7:2] == `OAS_A_AMP0 >> 2);
   // rate clamped against the pulse width written with it
   wire [1:0] pw_w = reg_wdata[`OAS_PW_MSB:0];
   wire [2:0] sr_w = reg_wdata[`OAS_SR_MSB:`OAS_SR_LSB];
   wire [2:0] sr_ok = (sr_w > sr_max(pw_w)) ? sr_max(pw_w) : sr_w;
   wire [7:0] acq_w = {1'b0, reg_wdata[`OAS_RGE_MSB:`OAS_RGE_LSB], sr_ok, pw_w};

   // current settings
   wire [2:0] mode = mode_reg[`OAS_MODE_MSB:0];
   wire [1:0] pw = acq_reg[`OAS_PW_MSB:0];
   wire [1:0] rge = acq_reg[`OAS_RGE_MSB:`OAS_RGE_LSB];
   wire [2:0] sr = acq_reg[`OAS_SR_MSB:`OAS_SR_LSB];
   wire mode_ok = !mode_reg[`OAS_SHDN_BIT] && (mode == oas_pkg::MODE_HEART ||
                  mode == oas_pkg::MODE_DUAL || mode == oas_pkg::MODE_SLOT);
   wire [14:0] fs_na = (rge == 2'h0) ? `OAS_FS0_NA : (rge == 2'h1) ? `OAS_FS1_NA :
                       (rge == 2'h2) ? `OAS_FS2_NA : `OAS_FS3_NA;
   wire [4:0] res_bits = (pw == 2'h0) ? `OAS_RES0 : (pw == 2'h1) ? `OAS_RES1 :
                         (pw == 2'h2) ? `OAS_RES2 : `OAS_RES3;

   // microsecond time base
   wire tick = (pre_reg == 8'(US_CYC - 1));
   wire pulse_start = (st_reg == oas_pkg::ST_SCAN) && (st_next == oas_pkg::ST_PULSE);
   wire [7:0] pre_next = (tick || pulse_start) ? 8'h00 : 8'(pre_reg + 8'h01);

   // sample period timer and pending start, a new period wins over a take
   wire wrap = mode_ok && tick && (sample_us_reg >= 15'(period_us(sr) - 15'h0001));
   wire take = (st_reg == oas_pkg::ST_IDLE) && pend_reg && mode_ok;
   wire pend_next = mode_ok && (wrap || (pend_reg && !take));
   wire [14:0] sample_us_next = (!mode_ok || wrap) ? 15'h0000 :
                                tick ? 15'(sample_us_reg + 15'h0001) : sample_us_reg;

   // temperature conversion, a new trigger wins over completion
   wire temp_done = trig_reg && tick && (temp_us_reg == 16'(TEMP_CONV_US - 1));
   wire trig_set = wr_trig && reg_wdata[`OAS_TRIG_BIT];
   wire trig_next = trig_set || (trig_reg && !temp_done);
   wire [15:0] temp_us_next = (!trig_reg || temp_done) ? 16'h0000 :
                              tick ? 16'(temp_us_reg + 16'h0001) : temp_us_reg;

   // slot decode for the channel under consideration
   wire [2:0] scan_src = chan_src(mode, k_reg[1:0], slot_lo_reg, slot_hi_reg);
   wire src_live = (scan_src != oas_pkg::SRC_OFF) && (scan_src <= oas_pkg::SRC_DARK);
   wire [3:0] led_mask = (src_reg == oas_pkg::SRC_RED) ? 4'h1 :
                         (src_reg == oas_pkg::SRC_IR) ? 4'h2 :
                         (src_reg == oas_pkg::SRC_GREEN) ? 4'hC : 4'h0;
   wire pulsing = (st_reg == oas_pkg::ST_PULSE);
   // low bits below the active resolution are cleared
   wire [1:0] lsb_drop = 2'(2'h3 - pw);
   wire [`OAS_ADC_W-1:0] adc_masked = (adc_result >> lsb_drop) << lsb_drop;

   // byte buffer handshake
   wire in_ready = !skid_v_reg;
   wire push = (st_reg == oas_pkg::ST_EMIT) && in_ready;
   wire [7:0] emit_byte = (byte_reg == 2'h0) ? {6'h00, samp_reg[17:16]} :
                          (byte_reg == 2'h1) ? samp_reg[15:8] : samp_reg[7:0];
   wire out_free = !fifo_valid || fifo_ready;

   // readback selection
   wire [7:0] rd_mux = (reg_addr == `OAS_A_MODE) ? mode_reg :
                       (reg_addr == `OAS_A_ACQ) ? acq_reg :
                       (reg_addr[7:2] == `OAS_A_AMP0 >> 2) ? amp_reg[reg_addr[1:0]] :
                       (reg_addr == `OAS_A_SLOT_LO) ? slot_lo_reg :
                       (reg_addr == `OAS_A_SLOT_HI) ? slot_hi_reg :
                       (reg_addr == `OAS_A_TWHOLE) ? twhole_reg :
                       (reg_addr == `OAS_A_TEMP_FRAC) ? {4'h0, temp_frac_reg} :
                       (reg_addr == `OAS_A_TTRIG) ? {7'h00, trig_reg} : 8'h00;

   // slot sequencer next state
   always_comb begin
      st_next = st_reg;
      k_next = k_reg;
      src_next = src_reg;
      byte_next = byte_reg;
      samp_next = samp_reg;
      chan_us_next = (tick && chan_us_reg != 11'h7FF) ? 11'(chan_us_reg + 11'h001) : chan_us_reg;
      unique case (st_reg)
         oas_pkg::ST_IDLE: begin
            if (take) begin
               st_next = oas_pkg::ST_SCAN;
               k_next = 3'h0;
            end
         end
         oas_pkg::ST_SCAN: begin
            if (!mode_ok || k_reg[2]) begin
               st_next = oas_pkg::ST_IDLE;
            end else if (src_live) begin
               st_next = oas_pkg::ST_PULSE;
               src_next = scan_src;
               chan_us_next = 11'h000;
            end else begin
               k_next = 3'(k_reg + 3'h1);
            end
         end
         oas_pkg::ST_PULSE: begin
            if (tick && chan_us_reg >= 11'(pw_us(pw) - 11'h001)) begin
               st_next = oas_pkg::ST_EMIT;
               samp_next = adc_masked;
               byte_next = 2'h0;
            end
         end
         oas_pkg::ST_EMIT: begin
            if (push) begin
               byte_next = 2'(byte_reg + 2'h1);
               if (byte_reg == 2'h2) begin
                  st_next = oas_pkg::ST_SPACE;
                  k_next = 3'(k_reg + 3'h1);
               end
            end
         end
         oas_pkg::ST_SPACE: begin
            if (chan_us_reg >= spc_us(pw)) begin
               st_next = oas_pkg::ST_SCAN;
            end
         end
         default: st_next = oas_pkg::ST_IDLE;
      endcase
   end

   // configuration registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg <= `OAS_RST_BYTE;
         acq_reg <= `OAS_RST_BYTE;
         amp_reg <= '{default: `OAS_RST_BYTE};
         slot_lo_reg <= `OAS_RST_BYTE;
         slot_hi_reg <= `OAS_RST_BYTE;
      end else begin
         if (wr_mode) mode_reg <= {reg_wdata[`OAS_SHDN_BIT], 4'h0, reg_wdata[`OAS_MODE_MSB:0]};
         if (wr_acq) acq_reg <= acq_w;
         if (amp_hit) amp_reg[reg_addr[1:0]] <= reg_wdata;
         if (wr_lo) slot_lo_reg <= {2'h0, reg_wdata[5:0]};
         if (wr_hi) slot_hi_reg <= {2'h0, reg_wdata[5:0]};
      end
   end

   // temperature registers, a finished conversion overrides a software write
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         twhole_reg <= `OAS_RST_BYTE;
         temp_frac_reg <= 4'h0;
         trig_reg <= 1'b0;
         temp_us_reg <= 16'h0000;
      end else begin
         trig_reg <= trig_next;
         temp_us_reg <= temp_us_next;
         if (temp_done) twhole_reg <= temp_sensor_whole;
         else if (wr_tw) twhole_reg <= reg_wdata;
         if (temp_done) temp_frac_reg <= temp_sensor_frac;
         else if (wr_tf) temp_frac_reg <= reg_wdata[`OAS_TEMP_FRAC_MSB:0];
      end
   end

   // sequencer state and timers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= oas_pkg::ST_IDLE;
         k_reg <= 3'h0;
         src_reg <= 3'h0;
         byte_reg <= 2'h0;
         samp_reg <= '0;
         chan_us_reg <= 11'h000;
         pre_reg <= 8'h00;
         sample_us_reg <= 15'h0000;
         pend_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         k_reg <= k_next;
         src_reg <= src_next;
         byte_reg <= byte_next;
         samp_reg <= samp_next;
         chan_us_reg <= chan_us_next;
         pre_reg <= pre_next;
         sample_us_reg <= sample_us_next;
         pend_reg <= pend_next;
      end
   end

   // two-entry skid buffer toward the sample fifo
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fifo_valid <= 1'b0;
         fifo_byte <= 8'h00;
         skid_v_reg <= 1'b0;
         skid_reg <= 8'h00;
      end else if (out_free) begin
         fifo_valid <= skid_v_reg || push;
         fifo_byte <= skid_v_reg ? skid_reg : emit_byte;
         skid_v_reg <= 1'b0;
      end else if (push) begin
         skid_reg <= emit_byte; // receiver stalled, park the byte
         skid_v_reg <= 1'b1;
      end
   end

   // registered outputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
         adc_integrate <= 1'b0;
         adc_full_scale_na <= `OAS_FS0_NA;
         adc_resolution_bits <= `OAS_RES0;
         temp_conv_active <= 1'b0;
         led_enable <= 4'h0;
         red_drive_level <= 8'h00;
         infrared_drive_level <= 8'h00;
         green_a_drive_level <= 8'h00;
         green_b_drive_level <= 8'h00;
      end else begin
         if (reg_rd) reg_rdata <= rd_mux;
         adc_integrate <= pulsing;
         adc_full_scale_na <= fs_na;
         adc_resolution_bits <= res_bits;
         temp_conv_active <= trig_reg;
         led_enable <= pulsing ? led_mask : 4'h0;
         red_drive_level <= (pulsing && led_mask[0]) ? amp_reg[0] : 8'h00;
         infrared_drive_level <= (pulsing && led_mask[1]) ? amp_reg[1] : 8'h00;
         green_a_drive_level <= (pulsing && led_mask[2]) ? amp_reg[2] : 8'h00;
         green_b_drive_level <= (pulsing && led_mask[3]) ? amp_reg[3] : 8'h00;
      end
   end

endmodule // oas_sequencer
`default_nettype wire

// ### test/oas_sink_model.sv
// Purpose: receiver model for the sample byte stream
// Assumes: bytes are taken when valid and ready meet at a rising edge
// Notes: the bench stalls it through stall and reads the got queue
`timescale 1ns/1ps
`default_nettype none
module oas_sink_model (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // stall control from the bench
   input wire logic stall,
   // byte stream
   input wire logic [7:0] fifo_byte,
   input wire logic fifo_valid,
   output logic fifo_ready
);
   logic [7:0] got [$];
   // refuse bytes while stalled
   assign fifo_ready = !stall;
   // keep every byte accepted
   always @(posedge clock) begin
      if (arst_n && fifo_valid && fifo_ready) got.push_back(fifo_byte);
   end
endmodule // oas_sink_model
`default_nettype wire

// ### test/oas_sequencer_props.sv
// Purpose: port-level checks of the acquisition sequencer
// Assumes: one clock domain, reset active low
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "oas_defines.svh"
module oas_sequencer_props #(
   parameter int unsigned US_CYC = 10,
   parameter int unsigned TEMP_CONV_US = 100
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // converter and led side
   input wire logic adc_integrate,
   input wire logic [14:0] adc_full_scale_na,
   input wire logic [4:0] adc_resolution_bits,
   input wire logic temp_conv_active,
   input wire logic [3:0] led_enable,
   input wire logic [7:0] red_drive_level,
   // byte stream
   input wire logic [7:0] fifo_byte,
   input wire logic fifo_valid,
   input wire logic fifo_ready
);
   localparam int CONV_MAX = 2 * (TEMP_CONV_US + 1) * US_CYC + 8;
   logic [15:0] hi_len_reg;
   logic [15:0] since_rise_reg;
   logic [15:0] conv_len_reg;
   logic [1:0] byte_idx_reg;
   logic rise_seen_reg;
   wire [10:0] pw_us;
   wire [10:0] spc_us;
   // pulse width and spacing implied by the resolution output
   assign pw_us = (adc_resolution_bits == 5'h12) ? `OAS_PW3_US :
      (adc_resolution_bits == 5'h11) ? `OAS_PW2_US :
      (adc_resolution_bits == 5'h10) ? `OAS_PW1_US : `OAS_PW0_US;
   assign spc_us = (adc_resolution_bits == 5'h12) ? `OAS_SPC3_US :
      (adc_resolution_bits == 5'h11) ? `OAS_SPC2_US :
      (adc_resolution_bits == 5'h10) ? `OAS_SPC1_US : `OAS_SPC0_US;
   // run lengths, rise spacing and byte position in a slot
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hi_len_reg <= 16'h0000;
         since_rise_reg <= 16'h0000;
         conv_len_reg <= 16'h0000;
         byte_idx_reg <= 2'h0;
         rise_seen_reg <= 1'b0;
      end else begin
         hi_len_reg <= adc_integrate ? hi_len_reg + 16'h0001 : 16'h0000;
         since_rise_reg <= (adc_integrate && hi_len_reg == 16'h0000) ? 16'h0001 :
            since_rise_reg + {15'h0000, ~&since_rise_reg};
         conv_len_reg <= temp_conv_active ? conv_len_reg + 16'h0001 : 16'h0000;
         if (fifo_valid && fifo_ready) begin
            byte_idx_reg <= (byte_idx_reg == 2'h2) ? 2'h0 : byte_idx_reg + 2'h1;
         end
         if (adc_integrate) rise_seen_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   sequence acq_write_s;
      reg_wr && reg_addr == `OAS_A_ACQ;
   endsequence
   sequence acq_settled_s;
      acq_write_s ##1 !(reg_wr && reg_addr == `OAS_A_ACQ);
   endsequence
   full_scale_a: assert property (
      acq_settled_s |=> adc_full_scale_na == (15'h0800 << $past(reg_wdata[6:5], 2)))
      else $error("full scale does not follow range code");
   resolution_a: assert property (
      acq_settled_s |=> adc_resolution_bits == 5'h0F + {3'h0, $past(reg_wdata[1:0], 2)})
      else $error("resolution does not follow width code");
   temp_start_a: assert property (
      reg_wr && reg_addr == `OAS_A_TTRIG && reg_wdata[0] |-> ##2 temp_conv_active)
      else $error("conversion did not start");
   temp_end_a: assert property (conv_len_reg <= CONV_MAX)
      else $error("conversion never finished");
   stream_hold_a: assert property (
      fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_byte))
      else $error("stalled byte dropped or changed");
   byte_top_a: assert property (
      fifo_valid && byte_idx_reg == 2'h0 |-> fifo_byte[7:2] == 6'h00)
      else $error("first byte of slot has upper bits set");
   pulse_width_a: assert property ($fell(adc_integrate) |-> hi_len_reg == pw_us * US_CYC)
      else $error("pulse length wrong");
   rise_space_a: assert property (
      $rose(adc_integrate) && rise_seen_reg |-> since_rise_reg >= spc_us * US_CYC)
      else $error("pulses too close");
   green_pair_a: assert property (led_enable[2] == led_enable[3])
      else $error("green channels not paired");
   one_led_a: assert property ($onehot0(led_enable[2:0]))
      else $error("several leds lit");
   red_dark_a: assert property (!led_enable[0] |-> red_drive_level == 8'h00)
      else $error("red drive while off");
endmodule // oas_sequencer_props
bind oas_sequencer oas_sequencer_props #(.US_CYC(US_CYC), .TEMP_CONV_US(TEMP_CONV_US))
   u_oas_sequencer_props (.*);
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench of the acquisition sequencer
// Assumes: one cycle per microsecond, short temperature conversion
// Notes: table rows cover register access, hand tests the rest
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} oas_row_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic stall = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [17:0] adc_result = 18'h2ABCD;
   logic [7:0] temp_sensor_whole = 8'h81;
   logic [3:0] temp_sensor_frac = 4'hC;
   logic [7:0] reg_rdata, fifo_byte, d, w, seen_r, seen_ir, seen_ga, seen_gb;
   logic adc_integrate, temp_conv_active, fifo_valid, fifo_ready;
   logic [14:0] adc_full_scale_na;
   logic [4:0] adc_resolution_bits;
   logic [3:0] led_enable;
   logic [7:0] red_drive_level, infrared_drive_level, green_a_drive_level, green_b_drive_level;
   int n_mismatch = 0;
   int n_compared = 0;
   oas_row_t rows [10] = '{'{8'h0C, 8'h5A, 8'h5A}, '{8'h0D, 8'hA5, 8'hA5},
      '{8'h0E, 8'hFF, 8'hFF}, '{8'h0F, 8'h01, 8'h01}, '{8'h11, 8'hFF, 8'h3F},
      '{8'h12, 8'hC9, 8'h09}, '{8'h0A, 8'hFF, 8'h73}, '{8'h0A, 8'h1D, 8'h19},
      '{8'h20, 8'hFF, 8'h0F}, '{8'h30, 8'hAA, 8'h00}};
   logic [7:0] modes [3] = '{8'h07, 8'h03, 8'h02};
   logic [15:0] nbytes [3] = '{16'h0009, 16'h0006, 16'h0003};
   logic [7:0] pat [3] = '{8'h02, 8'hAB, 8'hC8};
   oas_sequencer #(.US_CYC(1), .TEMP_CONV_US(20)) u_oas_sequencer (.*);
   oas_sink_model u_oas_sink_model (.*);
   // clock of 100 ns
   always #50 clock = ~clock;
   // drive levels seen while each led is lit, cleared as each mode starts
   always @(posedge clock) begin
      if (reg_wr && reg_addr == 8'h09 && reg_wdata != 8'h00) begin
         seen_r <= 8'h00;
         seen_ir <= 8'h00;
         seen_ga <= 8'h00;
         seen_gb <= 8'h00;
      end
      if (led_enable[0]) seen_r <= red_drive_level;
      if (led_enable[1]) seen_ir <= infrared_drive_level;
      if (led_enable[2]) seen_ga <= green_a_drive_level;
      if (led_enable[3]) seen_gb <= green_b_drive_level;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      v = reg_rdata;
   endtask
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, d);
         cmp_byte(d, rows[i].e);
      end
      $display("test registers done");
      wr(8'h21, 8'h01);
      rd(8'h21, d);
      cmp_byte(d, 8'h01);
      wr(8'h21, 8'h00);
      rd(8'h21, d);
      cmp_byte(d, 8'h01);
      for (int i = 0; i < 40 && d !== 8'h00; i++) rd(8'h21, d);
      cmp_byte(d, 8'h00);
      rd(8'h1F, d);
      cmp_byte(d, 8'h81);
      rd(8'h20, w);
      cmp_byte(w, 8'h0C);
      cmp_val({{4{d[7]}}, d, w[3:0]}, 16'hF81C);
      $display("test temperature done");
      wr(8'h0A, 8'h0C);
      wr(8'h0C, 8'h11);
      wr(8'h0D, 8'h22);
      wr(8'h0E, 8'h33);
      wr(8'h0F, 8'h44);
      wr(8'h11, 8'h19);
      wr(8'h12, 8'h2C);
      for (int m = 0; m < 3; m++) begin
         u_oas_sink_model.got.delete();
         stall <= (m == 0);
         wr(8'h09, modes[m]);
         repeat (2700) @(posedge clock);
         stall <= 1'b0;
         repeat (1300) @(posedge clock);
         wr(8'h09, 8'h00);
         cmp_val(16'(u_oas_sink_model.got.size()), nbytes[m]);
         for (int k = 0; k < u_oas_sink_model.got.size(); k++) begin
            cmp_byte(u_oas_sink_model.got[k], pat[k % 3]);
         end
         cmp_byte(seen_r, 8'h11);
         cmp_byte(seen_ir, (m == 1) ? 8'h22 : 8'h00);
         cmp_byte(seen_ga, (m == 0) ? 8'h33 : 8'h00);
         cmp_byte(seen_gb, (m == 0) ? 8'h44 : 8'h00);
         $display("test stream mode %h done", modes[m]);
      end
      wr(8'h0A, 8'hFF);
      wr(8'h0C, 8'h77);
      repeat (4) @(posedge clock);
      arst_n <= 1'b0;
      repeat (3) @(posedge clock);
      cmp_val({1'b0, adc_full_scale_na}, 16'h0800);
      cmp_val({11'h000, adc_resolution_bits}, 16'h000F);
      arst_n <= 1'b1;
      rd(8'h0C, d);
      cmp_byte(d, 8'h00);
      rd(8'h0A, d);
      cmp_byte(d, 8'h00);
      $display("test reset done");
      give_verdict();
   end
   // cut a hang short
   initial begin
      repeat (40000) @(posedge clock);
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
